// [hw/status_pkg.sv]
package status_pkg;
  // ************************************************
  // register byte offsets
  // ************************************************
  localparam logic [7:0] OPER_COND_OFS = 8'h00;
  localparam logic [7:0] OPER_PTR_OFS = 8'h04;
  localparam logic [7:0] OPER_NTR_OFS = 8'h08;
  localparam logic [7:0] OPER_EVENT_OFS = 8'h0c;
  localparam logic [7:0] OPER_ENAB_OFS = 8'h10;
  localparam logic [7:0] QUES_COND_OFS = 8'h14;
  localparam logic [7:0] QUES_PTR_OFS = 8'h18;
  localparam logic [7:0] QUES_NTR_OFS = 8'h1c;
  localparam logic [7:0] QUES_EVENT_OFS = 8'h20;
  localparam logic [7:0] QUES_ENAB_OFS = 8'h24;
  localparam logic [7:0] STD_EVENT_OFS = 8'h28;
  localparam logic [7:0] STD_ENAB_OFS = 8'h2c;
  localparam logic [7:0] STB_OFS = 8'h30;
  localparam logic [7:0] SRE_OFS = 8'h34;
  localparam logic [7:0] CMD_OFS = 8'h38;
  localparam logic [7:0] STATE_OFS = 8'h3c;
  localparam logic [7:0] FAULT_SEL_OFS = 8'h40;
  localparam logic [7:0] OUTQ_OFS = 8'h44;
  localparam logic [7:0] POLL_OFS = 8'h48;
  // ************************************************
  // bit positions
  // ************************************************
  localparam int CONST_VOLTAGE_BIT = 8;
  localparam int CONST_CURRENT_BIT = 10;
  localparam int OVERVOLTAGE_BIT = 0;
  localparam int OVERCURRENT_BIT = 1;
  localparam int OVERTEMP_BIT = 4;
  localparam int REMOTE_INHIBIT_BIT = 9;
  localparam int QUES_SUM_BIT = 3;
  localparam int MSG_AVAIL_BIT = 4;
  localparam int ESB_BIT = 5;
  localparam int RQS_BIT = 6;
  localparam int OPER_SUM_BIT = 7;
  localparam int OPC_BIT = 0;
  localparam int CMD_WAI_BIT = 0;
  localparam int CMD_OPC_BIT = 1;
  localparam int CMD_OPCQ_BIT = 2;
  localparam int CMD_CLS_BIT = 3;
  localparam int CMD_DCL_BIT = 4;
  // ************************************************
  // reset values and sizes
  // ************************************************
  localparam logic [15:0] PTR_RESET = 16'hffff;
  localparam logic [15:0] NTR_RESET = 16'h0000;
  localparam logic [15:0] ENAB_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] FAULT_SEL_RESET = 3'h0;
  localparam logic [7:0] OPC_REPLY = 8'h01;
  localparam int OUTQ_DEPTH = 4;
endpackage : status_pkg

// [hw/status_reporting.sv]
`timescale 1ns/10ps
module status_reporting (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic const_current_cond,
  input wire logic const_voltage_cond,
  input wire logic overcurrent_cond,
  input wire logic overtemp_cond,
  input wire logic overvoltage_cond,
  input wire logic inhibit_input,
  input wire logic dev_clear_in,
  input wire logic [7:1] std_event_in,
  input wire logic trig_initiated,
  input wire logic cmd_valid,
  input wire logic cmd_parallel,
  input wire logic seq_done,
  input wire logic par_done,
  input wire logic outq_push,
  input wire logic [7:0] outq_data,
  output logic cmd_ready,
  output logic buf_clear,
  output logic srq_out,
  output logic fault_indicator_out
);
  import status_pkg::*;

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic [6:0] pin_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
      pin_prev <= 7'h00;
    end else begin
      pin_meta <= {dev_clear_in, inhibit_input, overvoltage_cond, overtemp_cond,
                   overcurrent_cond, const_voltage_cond, const_current_cond};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  logic dcl_pulse;
  assign dcl_pulse = pin_sync[6] & ~pin_prev[6];

  logic [15:0] oper_cond;
  logic [15:0] ques_cond;
  logic [15:0] oper_prev;
  logic [15:0] ques_prev;
  always_comb begin
    oper_cond = 16'h0000;
    ques_cond = 16'h0000;
    oper_prev = 16'h0000;
    ques_prev = 16'h0000;
    oper_cond[CONST_CURRENT_BIT] = pin_sync[0];
    oper_cond[CONST_VOLTAGE_BIT] = pin_sync[1];
    oper_prev[CONST_CURRENT_BIT] = pin_prev[0];
    oper_prev[CONST_VOLTAGE_BIT] = pin_prev[1];
    ques_cond[OVERCURRENT_BIT] = pin_sync[2];
    ques_cond[OVERTEMP_BIT] = pin_sync[3];
    ques_cond[OVERVOLTAGE_BIT] = pin_sync[4];
    ques_cond[REMOTE_INHIBIT_BIT] = pin_sync[5];
    ques_prev[OVERCURRENT_BIT] = pin_prev[2];
    ques_prev[OVERTEMP_BIT] = pin_prev[3];
    ques_prev[OVERVOLTAGE_BIT] = pin_prev[4];
    ques_prev[REMOTE_INHIBIT_BIT] = pin_prev[5];
  end

  // ************************************************
  // apb slave
  // ************************************************
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] next_rdata;
  logic hit;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & penable & pready & ~pwrite;

  logic [15:0] oper_ptr;
  logic [15:0] oper_ntr;
  logic [15:0] oper_event;
  logic [15:0] oper_enab;
  logic [15:0] ques_ptr;
  logic [15:0] ques_ntr;
  logic [15:0] ques_event;
  logic [15:0] ques_enab;
  logic [7:0] std_event;
  logic [7:0] std_enab;
  logic [7:0] sre;
  logic [2:0] fault_sel;
  logic rqs;
  logic [7:0] stb;
  logic mss;
  logic oper_sum;
  logic ques_sum;
  logic esb_sum;
  logic message_available_bit;
  logic seq_busy;
  logic wai_hold;
  logic opc_armed;
  logic opcq_armed;
  logic [3:0] par_count;
  logic all_done;
  logic [7:0] outq_mem [OUTQ_DEPTH];
  logic [1:0] outq_rd;
  logic [1:0] outq_wr;
  logic [2:0] outq_count;

  always_comb begin
    next_rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      OPER_COND_OFS: next_rdata = {16'h0000, oper_cond};
      OPER_PTR_OFS: next_rdata = {16'h0000, oper_ptr};
      OPER_NTR_OFS: next_rdata = {16'h0000, oper_ntr};
      OPER_EVENT_OFS: next_rdata = {16'h0000, oper_event};
      OPER_ENAB_OFS: next_rdata = {16'h0000, oper_enab};
      QUES_COND_OFS: next_rdata = {16'h0000, ques_cond};
      QUES_PTR_OFS: next_rdata = {16'h0000, ques_ptr};
      QUES_NTR_OFS: next_rdata = {16'h0000, ques_ntr};
      QUES_EVENT_OFS: next_rdata = {16'h0000, ques_event};
      QUES_ENAB_OFS: next_rdata = {16'h0000, ques_enab};
      STD_EVENT_OFS: next_rdata = {24'h000000, std_event};
      STD_ENAB_OFS: next_rdata = {24'h000000, std_enab};
      STB_OFS: next_rdata = {24'h000000, stb[7], mss, stb[5:0]};
      SRE_OFS: next_rdata = {24'h000000, sre};
      CMD_OFS: next_rdata = 32'h0000_0000;
      STATE_OFS: next_rdata = {24'h000000, par_count, seq_busy, wai_hold,
                               opc_armed, opcq_armed};
      FAULT_SEL_OFS: next_rdata = {29'h0000_0000, fault_sel};
      OUTQ_OFS: next_rdata = {24'h000000, message_available_bit ? outq_mem[outq_rd] : 8'h00};
      POLL_OFS: next_rdata = {24'h000000, stb};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  logic wr_ok;
  logic rd_ok;
  assign wr_ok = wr_acc & ~pslverr;
  assign rd_ok = rd_acc & ~pslverr;
  logic cmd_wr;
  assign cmd_wr = wr_ok & (paddr == CMD_OFS);
  logic cls;
  assign cls = cmd_wr & pwdata[CMD_CLS_BIT];

  // ************************************************
  // filters and enables
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper_ptr <= PTR_RESET;
      oper_ntr <= NTR_RESET;
      oper_enab <= ENAB_RESET;
      ques_ptr <= PTR_RESET;
      ques_ntr <= NTR_RESET;
      ques_enab <= ENAB_RESET;
      std_enab <= BYTE_RESET;
      sre <= BYTE_RESET;
      fault_sel <= FAULT_SEL_RESET;
    end else if (wr_ok) begin
      case (paddr)
        OPER_PTR_OFS: oper_ptr <= pwdata[15:0];
        OPER_NTR_OFS: oper_ntr <= pwdata[15:0];
        OPER_ENAB_OFS: oper_enab <= pwdata[15:0];
        QUES_PTR_OFS: ques_ptr <= pwdata[15:0];
        QUES_NTR_OFS: ques_ntr <= pwdata[15:0];
        QUES_ENAB_OFS: ques_enab <= pwdata[15:0];
        STD_ENAB_OFS: std_enab <= pwdata[7:0];
        SRE_OFS: sre <= pwdata[7:0];
        FAULT_SEL_OFS: fault_sel <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // ************************************************
  // event latches, set wins over clear
  // ************************************************
  logic [15:0] oper_set;
  logic [15:0] ques_set;
  logic [15:0] oper_clr;
  logic [15:0] ques_clr;
  assign oper_set = (oper_cond & ~oper_prev & oper_ptr) | (~oper_cond & oper_prev & oper_ntr);
  assign ques_set = (ques_cond & ~ques_prev & ques_ptr) | (~ques_cond & ques_prev & ques_ntr);
  assign oper_clr = (rd_ok && paddr == OPER_EVENT_OFS) ? prdata[15:0] : 16'h0000;
  assign ques_clr = (rd_ok && paddr == QUES_EVENT_OFS) ? prdata[15:0] : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper_event <= ENAB_RESET;
      ques_event <= ENAB_RESET;
    end else if (cls) begin
      oper_event <= oper_set;
      ques_event <= ques_set;
    end else begin
      oper_event <= (oper_event & ~oper_clr) | oper_set;
      ques_event <= (ques_event & ~ques_clr) | ques_set;
    end
  end

  logic [7:0] std_set;
  logic [7:0] std_clr;
  logic opc_fire;
  assign std_set = {std_event_in, opc_fire};
  assign std_clr = (rd_ok && paddr == STD_EVENT_OFS) ? prdata[7:0] : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_event <= BYTE_RESET;
    end else if (cls) begin
      std_event <= std_set;
    end else begin
      std_event <= (std_event & ~std_clr) | std_set;
      if (trig_initiated) begin
        std_event[OPC_BIT] <= 1'b0;
      end
    end
  end

  // ************************************************
  // summaries and status byte
  // ************************************************
  // event and enable
  assign oper_sum = |(oper_event & oper_enab);
  assign ques_sum = |(ques_event & ques_enab);
  assign esb_sum = |(std_event & std_enab);
  assign message_available_bit = (outq_count != 3'h0);

  always_comb begin
    stb = 8'h00;
    stb[OPER_SUM_BIT] = oper_sum;
    stb[QUES_SUM_BIT] = ques_sum;
    stb[MSG_AVAIL_BIT] = message_available_bit;
    stb[ESB_BIT] = esb_sum;
    stb[RQS_BIT] = rqs;
  end
  assign mss = |({stb[7], 1'b0, stb[5:0]} & {sre[7], 1'b0, sre[5:0]});

  logic mss_prev;
  logic poll_rd;
  assign poll_rd = rd_ok & (paddr == POLL_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mss_prev <= 1'b0;
      rqs <= 1'b0;
      srq_out <= 1'b0;
    end else begin
      mss_prev <= mss;
      // new reason sets request, poll clears
      if (mss && !mss_prev) begin
        rqs <= 1'b1;
        srq_out <= 1'b1;
      end else if (poll_rd && prdata[RQS_BIT]) begin
        rqs <= 1'b0;
        srq_out <= 1'b0;
      end
    end
  end

  // ************************************************
  // fault indicator
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_indicator_out <= 1'b0;
    end else begin
      fault_indicator_out <= |(fault_sel & {esb_sum, oper_sum, ques_sum});
    end
  end

  // ************************************************
  // command completion
  // ************************************************
  logic dclr;
  logic take;
  assign dclr = dcl_pulse | (cmd_wr & pwdata[CMD_DCL_BIT]);
  assign take = cmd_valid & cmd_ready;
  assign all_done = ~seq_busy & (par_count == 4'h0) & ~trig_initiated;
  assign opc_fire = opc_armed & all_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_busy <= 1'b0;
      par_count <= 4'h0;
    end else begin
      if (take && !cmd_parallel) begin
        seq_busy <= 1'b1;
      end else if (seq_done || dclr) begin
        seq_busy <= 1'b0;
      end
      if (take && cmd_parallel && !par_done && par_count != 4'hf) begin
        par_count <= par_count + 4'h1;
      end else if (par_done && !(take && cmd_parallel) && par_count != 4'h0) begin
        par_count <= par_count - 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wai_hold <= 1'b0;
      opc_armed <= 1'b0;
      opcq_armed <= 1'b0;
    end else begin
      if (cmd_wr && pwdata[CMD_WAI_BIT]) begin
        wai_hold <= 1'b1;
      end else if (all_done || dclr) begin
        wai_hold <= 1'b0;
      end
      if (cmd_wr && pwdata[CMD_OPC_BIT]) begin
        opc_armed <= 1'b1;
      end else if (opc_fire || dclr) begin
        opc_armed <= 1'b0;
      end
      if (cmd_wr && pwdata[CMD_OPCQ_BIT]) begin
        opcq_armed <= 1'b1;
      end else if (all_done || dclr) begin
        opcq_armed <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ready <= 1'b0;
      buf_clear <= 1'b0;
    end else begin
      cmd_ready <= ~seq_busy & ~wai_hold & ~dclr & ~(take & ~cmd_parallel) &
                   ~(cmd_wr & pwdata[CMD_WAI_BIT]);
      buf_clear <= dclr;
    end
  end

  // ************************************************
  // output queue
  // ************************************************
  logic q_push;
  logic q_pop;
  logic [7:0] q_data;
  assign q_push = (opcq_armed & all_done) | outq_push;
  assign q_data = (opcq_armed & all_done) ? OPC_REPLY : outq_data;
  assign q_pop = rd_ok & (paddr == OUTQ_OFS) & message_available_bit;

  always_ff @(posedge pclk) begin
    if (q_push && outq_count != 3'(OUTQ_DEPTH)) begin
      outq_mem[outq_wr] <= q_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outq_rd <= 2'h0;
      outq_wr <= 2'h0;
      outq_count <= 3'h0;
    end else if (dclr || cls) begin
      outq_rd <= 2'h0;
      outq_wr <= 2'h0;
      outq_count <= 3'h0;
    end else begin
      if (q_push && (outq_count != 3'(OUTQ_DEPTH) || q_pop)) begin
        outq_wr <= outq_wr + 2'h1;
      end
      if (q_pop) begin
        outq_rd <= outq_rd + 2'h1;
      end
      if (q_push && !q_pop && outq_count != 3'(OUTQ_DEPTH)) begin
        outq_count <= outq_count + 3'h1;
      end else if (q_pop && !q_push) begin
        outq_count <= outq_count - 3'h1;
      end
    end
  end
endmodule : status_reporting

// [testbench/status_chk.sv]
`timescale 1ns/10ps
module status_chk
  import status_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmd_valid,
  input wire logic cmd_parallel,
  input wire logic cmd_ready,
  input wire logic buf_clear,
  input wire logic srq_out
);
  // ************************************************
  // port relations
  // ************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_SEQ_HOLD: assert property (cmd_valid && cmd_ready && !cmd_parallel |=> !cmd_ready)
    else $error("sequential command did not block");
  AST_PAR_FLOW: assert property (cmd_valid && cmd_ready && cmd_parallel && !psel
    |=> cmd_ready)
    else $error("parallel command blocked");
  AST_CLR_PULSE: assert property (buf_clear |=> !buf_clear)
    else $error("buffer clear longer than one cycle");
  AST_DCL: assert property (psel && penable && pready && pwrite && paddr == CMD_OFS
    && pwdata[CMD_DCL_BIT] |-> ##[1:3] buf_clear)
    else $error("device clear gave no buffer clear");
  AST_SRQ_FALL: assert property ($fell(srq_out)
    |-> $past(psel && penable && !pwrite && paddr == POLL_OFS))
    else $error("request dropped without poll");
endmodule : status_chk

bind status_reporting status_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_parallel(cmd_parallel),
  .cmd_ready(cmd_ready), .buf_clear(buf_clear), .srq_out(srq_out));

// [testbench/cmd_source.sv]
`timescale 1ns/10ps
module cmd_source #(
  parameter int DLY = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic go_par,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic cmd_parallel,
  output logic seq_done,
  output logic par_done
);
  // ************************************************
  // parser stand-in: offer, hold until taken, finish later
  // ************************************************
  logic [7:0] cnt;
  logic busy;
  logic kind;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid <= 1'b0;
      cmd_parallel <= 1'b0;
      seq_done <= 1'b0;
      par_done <= 1'b0;
      busy <= 1'b0;
      kind <= 1'b0;
      cnt <= 8'h00;
    end else begin
      seq_done <= 1'b0;
      par_done <= 1'b0;
      if (go && !cmd_valid && !busy) begin
        cmd_valid <= 1'b1;
        cmd_parallel <= go_par;
      end else if (cmd_valid && cmd_ready) begin
        // released qualifier shows the inverse, not the old value
        cmd_valid <= 1'b0;
        cmd_parallel <= ~cmd_parallel;
        kind <= cmd_parallel;
        busy <= 1'b1;
        cnt <= DLY[7:0];
      end
      if (busy) begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          busy <= 1'b0;
          seq_done <= !kind;
          par_done <= kind;
        end
      end
    end
  end
endmodule : cmd_source

// [testbench/instrument_status_reporting_tb_top.sv]
`timescale 1ns/10ps
module instrument_status_reporting_tb_top;
  import status_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, seen;
  logic [7:0] paddr, outq_data;
  logic [31:0] pwdata, prdata, rdat;
  logic ccur, cvolt, ocur, otemp, ovolt, inhib, dcl, trig, go, go_par, outq_push;
  logic [7:1] std_ev;
  logic cmd_valid, cmd_parallel, seq_done, par_done, cmd_ready, buf_clear, srq_out, fault;
  int errors, samples_checked;
  status_reporting u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .const_current_cond(ccur), .const_voltage_cond(cvolt),
    .overcurrent_cond(ocur), .overtemp_cond(otemp), .overvoltage_cond(ovolt),
    .inhibit_input(inhib), .dev_clear_in(dcl), .std_event_in(std_ev),
    .trig_initiated(trig), .cmd_valid(cmd_valid), .cmd_parallel(cmd_parallel),
    .seq_done(seq_done), .par_done(par_done), .outq_push(outq_push),
    .outq_data(outq_data), .cmd_ready(cmd_ready), .buf_clear(buf_clear),
    .srq_out(srq_out), .fault_indicator_out(fault));
  cmd_source u_par (.pclk(pclk), .presetn(presetn), .go(go), .go_par(go_par),
    .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_parallel(cmd_parallel),
    .seq_done(seq_done), .par_done(par_done));
  // ************************************************
  // helpers
  // ************************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task tally_and_finish;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task flag(input logic f, input logic e);
    check({31'h0, f}, {31'h0, e});
  endtask : flag
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      tally_and_finish;
    end else begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask : rd
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  task wait_ready(input logic v);
    int n;
    n = 0;
    while (cmd_ready !== v && n < 100) begin
      @(posedge pclk);
      n++;
    end
    flag(n < 100, 1'b1);
    if (n >= 100) tally_and_finish;
  endtask : wait_ready
  task catch_clear;
    seen = 1'b0;
    repeat (6) begin
      @(posedge pclk);
      seen = seen | buf_clear;
    end
  endtask : catch_clear
  task issue(input logic par);
    go <= 1'b1;
    go_par <= par;
    wt(1);
    go <= 1'b0;
  endtask : issue
  // ************************************************
  // scenarios
  // ************************************************
  task t_reset_vals;
    rd(OPER_PTR_OFS, 32'hffff);
    rd(QUES_NTR_OFS, 32'h0);
    rd(OPER_ENAB_OFS, 32'h0);
    rd(8'h80, 32'h0);
    flag(rerr, 1'b1);
  endtask : t_reset_vals
  task t_cc_path;
    wr(OPER_ENAB_OFS, 32'h400);
    wr(SRE_OFS, 32'h80);
    ccur <= 1'b1;
    wt(8);
    flag(srq_out, 1'b1);
    rd(POLL_OFS, 32'hc0);
    wt(2);
    flag(srq_out, 1'b0);
    rd(OPER_EVENT_OFS, 32'h400);
    rd(OPER_EVENT_OFS, 32'h0);
  endtask : t_cc_path
  task t_both_edges;
    wr(OPER_NTR_OFS, 32'h400);
    ccur <= 1'b0;
    wt(8);
    flag(srq_out, 1'b1);
    rd(OPER_EVENT_OFS, 32'h400);
    rd(POLL_OFS, 32'h40);
    wr(OPER_NTR_OFS, 32'h0);
  endtask : t_both_edges
  task t_mask;
    wr(OPER_ENAB_OFS, 32'h0);
    cvolt <= 1'b1;
    wt(8);
    flag(srq_out, 1'b0);
    wr(OPER_ENAB_OFS, 32'h500);
    wt(3);
    flag(srq_out, 1'b1);
    rd(POLL_OFS, 32'hc0);
    rd(OPER_EVENT_OFS, 32'h100);
  endtask : t_mask
  task t_ques;
    wr(QUES_ENAB_OFS, 32'h213);
    wr(SRE_OFS, 32'h88);
    wr(FAULT_SEL_OFS, 32'h1);
    ocur <= 1'b1;
    otemp <= 1'b1;
    ovolt <= 1'b1;
    inhib <= 1'b1;
    wt(8);
    flag(fault, 1'b1);
    flag(srq_out, 1'b1);
    rd(QUES_COND_OFS, 32'h213);
    rd(STB_OFS, 32'h48);
    rd(POLL_OFS, 32'h48);
    rd(QUES_EVENT_OFS, 32'h213);
    wt(3);
    flag(fault, 1'b0);
  endtask : t_ques
  task t_opc_query;
    issue(1'b0);
    wait_ready(1'b0);
    wr(CMD_OFS, 32'h4);
    rd(POLL_OFS, 32'h0);
    wait_ready(1'b1);
    wt(3);
    rd(POLL_OFS, 32'h10);
    rd(OUTQ_OFS, 32'h1);
    rd(POLL_OFS, 32'h0);
  endtask : t_opc_query
  task t_opc_bit;
    trig <= 1'b1;
    wr(CMD_OFS, 32'h2);
    wt(4);
    rd(STD_EVENT_OFS, 32'h0);
    trig <= 1'b0;
    wt(4);
    rd(STD_EVENT_OFS, 32'h1);
  endtask : t_opc_bit
  task t_cmd_flow;
    issue(1'b1);
    wt(4);
    flag(cmd_ready, 1'b1);
    wr(CMD_OFS, 32'h1);
    wt(1);
    flag(cmd_ready, 1'b0);
    wait_ready(1'b1);
  endtask : t_cmd_flow
  task t_dev_clear;
    outq_push <= 1'b1;
    outq_data <= 8'h5a;
    wt(1);
    outq_push <= 1'b0;
    wt(1);
    rd(POLL_OFS, 32'h10);
    wr(OPER_PTR_OFS, 32'h400);
    wr(CMD_OFS, 32'h10);
    rd(OUTQ_OFS, 32'h0);
    rd(OPER_PTR_OFS, 32'h400);
    dcl <= 1'b1;
    catch_clear;
    flag(seen, 1'b1);
    dcl <= 1'b0;
  endtask : t_dev_clear
  task t_fault_src;
    // operation summary as fault source
    wr(FAULT_SEL_OFS, 32'h2);
    ccur <= 1'b1;
    wt(8);
    flag(fault, 1'b1);
    flag(srq_out, 1'b1);
    rd(POLL_OFS, 32'hc0);
    rd(OPER_EVENT_OFS, 32'h400);
    wt(3);
    flag(fault, 1'b0);
    // standard event summary as fault source
    wr(STD_ENAB_OFS, 32'h80);
    wr(FAULT_SEL_OFS, 32'h4);
    std_ev <= 7'h40;
    wt(1);
    std_ev <= 7'h00;
    wt(3);
    flag(fault, 1'b1);
    rd(STD_EVENT_OFS, 32'h80);
    wt(3);
    flag(fault, 1'b0);
    // clear-status empties queue and events
    outq_push <= 1'b1;
    outq_data <= 8'h33;
    std_ev <= 7'h40;
    wt(1);
    outq_push <= 1'b0;
    std_ev <= 7'h00;
    wr(CMD_OFS, 32'h8);
    rd(POLL_OFS, 32'h0);
    rd(STD_EVENT_OFS, 32'h0);
  endtask : t_fault_src
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ccur, cvolt, ocur, otemp, ovolt, inhib, dcl, trig, go, go_par, outq_push} = '0;
    outq_data = 8'h00;
    std_ev = 7'h00;
    errors = 0;
    samples_checked = 0;
    wt(10);
    presetn <= 1'b1;
    wt(1);
    t_reset_vals;
    t_cc_path;
    t_both_edges;
    t_mask;
    t_ques;
    t_opc_query;
    t_opc_bit;
    t_cmd_flow;
    t_dev_clear;
    t_fault_src;
    tally_and_finish;
  end
endmodule : instrument_status_reporting_tb_top
